// *** verilog/otr_pkg.sv ***
// Constants, register map and state codes for the oscillator trim registers
package otr_pkg;

	// ==========================================
	// Bus geometry
	localparam int unsigned AW = 32;
	localparam int unsigned DW = 16;

	// ==========================================
	// Register offsets, kept exactly as printed
	localparam logic [AW-1:0] OFS_SLOW_RC = 32'h5000_0020;
	localparam logic [AW-1:0] OFS_SLOW_XTAL = 32'h5000_0022;
	localparam logic [AW-1:0] OFS_FAST_RC = 32'h5000_0024;
	localparam logic [AW-1:0] OFS_LP_RC = 32'h5000_0026;
	localparam logic [AW-1:0] OFS_REF_TRIM = 32'h0500_0028;
	localparam logic [AW-1:0] OFS_OSC_STATUS = 32'h5000_003C;

	// ==========================================
	// Field positions
	localparam int unsigned SRC_OFF_POS = 0;
	localparam int unsigned SRC_TRIM_LSB = 1;
	localparam int unsigned SX_ON_POS = 0;
	localparam int unsigned SX_RBIAS_LSB = 1;
	localparam int unsigned SX_CUR_LSB = 3;
	localparam int unsigned SX_AMPOFF_POS = 7;
	localparam int unsigned FRC_OFF_POS = 0;
	localparam int unsigned FRC_BIAS_LSB = 1;
	localparam int unsigned FRC_RANGE_LSB = 5;
	localparam int unsigned FRC_CAP_LSB = 7;
	localparam int unsigned LRC_ON_POS = 0;
	localparam int unsigned LRC_RES_POS = 1;
	localparam int unsigned LRC_CAP_LSB = 2;
	localparam int unsigned LRC_UNIT_POS = 7;
	localparam int unsigned LRC_BIAS_LSB = 8;
	localparam int unsigned REF_V_LSB = 0;
	localparam int unsigned REF_I_LSB = 5;
	localparam int unsigned ST_SLEEP_POS = 0;
	localparam int unsigned ST_FRC_POS = 1;
	localparam int unsigned ST_REFUSED_POS = 2;

	// ==========================================
	// Field reset values
	localparam logic [DW-1:0] SRC_TRIM_RST = 16'h0007;
	localparam logic [DW-1:0] SX_CUR_RST = 16'h0005;
	localparam logic [DW-1:0] SX_RBIAS_RST = 16'h0003;
	localparam logic [DW-1:0] FRC_CAP_RST = 16'h000F;
	localparam logic [DW-1:0] FRC_BIAS_RST = 16'h0007;
	localparam logic [DW-1:0] LRC_BIAS_RST = 16'h000A;
	localparam logic [DW-1:0] LRC_UNIT_RST = 16'h0001;
	localparam logic [DW-1:0] LRC_CAP_RST = 16'h001F;

	// Register resets built from the fields; all other fields reset to zero
	localparam logic [DW-1:0] SLOW_RC_RST = SRC_TRIM_RST << SRC_TRIM_LSB;
	localparam logic [DW-1:0] SLOW_XTAL_RST =
		(SX_CUR_RST << SX_CUR_LSB) | (SX_RBIAS_RST << SX_RBIAS_LSB);
	localparam logic [DW-1:0] FAST_RC_RST =
		(FRC_CAP_RST << FRC_CAP_LSB) | (FRC_BIAS_RST << FRC_BIAS_LSB);
	localparam logic [DW-1:0] LP_RC_RST = (LRC_BIAS_RST << LRC_BIAS_LSB)
		| (LRC_UNIT_RST << LRC_UNIT_POS) | (LRC_CAP_RST << LRC_CAP_LSB);
	localparam logic [DW-1:0] REF_TRIM_RST = 16'h0000;

	// Implemented bits per register
	localparam logic [DW-1:0] SLOW_RC_MASK = 16'h001F;
	localparam logic [DW-1:0] SLOW_XTAL_MASK = 16'h00FF;
	localparam logic [DW-1:0] FAST_RC_MASK = 16'h07FF;
	localparam logic [DW-1:0] LP_RC_MASK = 16'h0FFF;
	localparam logic [DW-1:0] REF_TRIM_MASK = 16'h03FF;

	// ==========================================
	// Sleep sequencer states
	typedef enum logic [2:0] {
		OTR_AWAKE = 3'h1,
		OTR_ASLEEP = 3'h2,
		OTR_WAKING = 3'h4
	} otr_state_e;

endpackage : otr_pkg

// *** verilog/otr_sync.sv ***
// Two-stage synchroniser for one asynchronous level
module otr_sync (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_async,
	output logic o_sync
);

	logic meta_q;
	logic sync_q;

	// ==========================================
	// Stage one is read only by stage two
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : otr_sync

// *** verilog/otr_reg16.sv ***
// One sixteen-bit control register with reset value and writable mask
module otr_reg16 #(
	parameter logic [15:0] RST = 16'h0000,
	parameter logic [15:0] MASK = 16'hFFFF
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_we,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_q
);

	logic [15:0] val_q;
	logic [15:0] val_d;

	// ==========================================
	// Unmapped bits stay zero whatever is written
	always_comb begin
		val_d = val_q;
		if (i_we) begin
			val_d = i_wdata & MASK;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			val_q <= RST & MASK;
		end else begin
			val_q <= val_d;
		end
	end

	assign o_q = val_q;

endmodule : otr_reg16

// *** verilog/oscillator_trim_regs.sv ***
// Oscillator and reference trim registers with sleep gating
//
// Summary of operation
// - Slow RC trim, bits 4:1, resets to 7, zero slowest, all ones fastest.
// - Slow RC off bit 0 stops the oscillator at once; resets to zero.
// - No sleep cycle is run while the slow RC oscillator is off.
// - Slow crystal bit 7 turns amplitude regulation off; for external clock.
// - Slow crystal bias current, bits 6:3, resets to 5.
// - Slow crystal bias resistor, bits 2:1, resets to 3; 00 largest.
// - Slow crystal bit 0 turns the crystal oscillator on; resets off.
// - Fast RC capacitance adjust, bits 10:7, resets to F; higher is slower.
// - Fast RC coarse range, bits 6:5, resets to 0; codes 2 and 3 equal.
// - Fast RC off bit 0 stops it at once; also off during sleep.
// - Low-power RC bit 7 adds unit capacitance; resets to one.
// - Low-power RC capacitance adjust, bits 6:2, resets to 1F.
// - Low-power RC bit 1 picks resistance; one is minimum, more power.
// - Low-power RC bit 0 enables it; bias field 11:8 resets to A.
// - Reference current trim, bits 9:5, signed code, resets to zero.
// - Reference voltage trim, bits 4:0, signed code, resets to zero.
//
// Local design decision: strobed register access.
module oscillator_trim_regs (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [31:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_sleep_req,
	input wire logic i_wake_req,
	input wire logic i_wakeup_pin,
	output logic [3:0] o_slow_rc_trim,
	output logic o_slow_rc_on,
	output logic o_slow_xtal_amp_reg_off,
	output logic [3:0] o_slow_xtal_bias_current,
	output logic [1:0] o_slow_xtal_bias_resistor,
	output logic o_slow_xtal_on,
	output logic [3:0] o_fast_rc_cap_adjust,
	output logic [1:0] o_fast_rc_coarse_range,
	output logic [3:0] o_fast_rc_bias,
	output logic o_fast_rc_on,
	output logic [3:0] o_lp_rc_ldo_bias,
	output logic o_lp_rc_unit_cap,
	output logic [4:0] o_lp_rc_cap_adjust,
	output logic o_lp_rc_res_adjust,
	output logic o_lp_rc_on,
	output logic [4:0] o_ref_current_trim,
	output logic [4:0] o_ref_voltage_trim,
	output logic o_sleep_active,
	output logic o_sleep_refused
);

	// ==========================================
	// Address decode helper

	// Exact match on the full address, no aliasing
	function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	// Extract an unsigned field from a register word
	function automatic logic [15:0] fld(input logic [15:0] word, input int unsigned lsb,
			input logic [15:0] wmask);
		fld = (word >> lsb) & wmask;
	endfunction : fld

	// ==========================================
	// Declarations
	logic we_slow_rc;
	logic we_slow_xtal;
	logic we_fast_rc;
	logic we_lp_rc;
	logic we_ref;
	logic we_status;
	logic [15:0] slow_rc_q;
	logic [15:0] slow_xtal_q;
	logic [15:0] fast_rc_q;
	logic [15:0] lp_rc_q;
	logic [15:0] ref_q;
	logic [15:0] status_word;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic wake_pin_s;
	otr_pkg::otr_state_e state_q;
	otr_pkg::otr_state_e state_d;
	logic refused_q;
	logic refused_d;
	logic refuse_evt;
	logic src_off;
	logic frc_off;
	logic [1:0] range_raw;
	logic [1:0] range_eff;
	logic slow_rc_on_q;
	logic slow_rc_on_d;
	logic fast_rc_on_q;
	logic fast_rc_on_d;
	logic [1:0] range_q;
	logic refuse_pulse_q;

	// ==========================================
	// Write strobes
	// Decoded per register; a miss writes nothing
	// mapped 16-bit locations
	assign we_slow_rc = i_wr & hit(i_addr, otr_pkg::OFS_SLOW_RC);
	assign we_slow_xtal = i_wr & hit(i_addr, otr_pkg::OFS_SLOW_XTAL);
	assign we_fast_rc = i_wr & hit(i_addr, otr_pkg::OFS_FAST_RC);
	assign we_lp_rc = i_wr & hit(i_addr, otr_pkg::OFS_LP_RC);
	assign we_ref = i_wr & hit(i_addr, otr_pkg::OFS_REF_TRIM);
	assign we_status = i_wr & hit(i_addr, otr_pkg::OFS_OSC_STATUS);

	// ==========================================
	// Control registers
	// slow RC trim reset
	otr_reg16 #(
		.RST(otr_pkg::SLOW_RC_RST),
		.MASK(otr_pkg::SLOW_RC_MASK)
	) u_slow_rc (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_we(we_slow_rc),
		.i_wdata(i_wdata),
		.o_q(slow_rc_q)
	);

	otr_reg16 #(
		.RST(otr_pkg::SLOW_XTAL_RST),
		.MASK(otr_pkg::SLOW_XTAL_MASK)
	) u_slow_xtal (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_we(we_slow_xtal),
		.i_wdata(i_wdata),
		.o_q(slow_xtal_q)
	);

	otr_reg16 #(
		.RST(otr_pkg::FAST_RC_RST),
		.MASK(otr_pkg::FAST_RC_MASK)
	) u_fast_rc (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_we(we_fast_rc),
		.i_wdata(i_wdata),
		.o_q(fast_rc_q)
	);

	otr_reg16 #(
		.RST(otr_pkg::LP_RC_RST),
		.MASK(otr_pkg::LP_RC_MASK)
	) u_lp_rc (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_we(we_lp_rc),
		.i_wdata(i_wdata),
		.o_q(lp_rc_q)
	);

	otr_reg16 #(
		.RST(otr_pkg::REF_TRIM_RST),
		.MASK(otr_pkg::REF_TRIM_MASK)
	) u_ref (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_we(we_ref),
		.i_wdata(i_wdata),
		.o_q(ref_q)
	);

	// ==========================================
	// Wakeup pin crossing
	// The pin is asynchronous to the bus clock
	otr_sync u_wake_sync (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_async(i_wakeup_pin),
		.o_sync(wake_pin_s)
	);

	// ==========================================
	// Sleep sequencer
	// Off bits as they stand after this edge, so a stop is never delayed
	assign src_off = we_slow_rc ? i_wdata[otr_pkg::SRC_OFF_POS] : slow_rc_q[otr_pkg::SRC_OFF_POS];
	assign frc_off = we_fast_rc ? i_wdata[otr_pkg::FRC_OFF_POS] : fast_rc_q[otr_pkg::FRC_OFF_POS];

	// Sleep is timed off the slow RC, so it must be running
	// refuse sleep without slow RC
	always_comb begin
		state_d = state_q;
		refuse_evt = 1'b0;
		case (state_q)
			otr_pkg::OTR_AWAKE: begin
				if (i_sleep_req) begin
					if (src_off) begin
						refuse_evt = 1'b1;
					end else begin
						state_d = otr_pkg::OTR_ASLEEP;
					end
				end
			end
			otr_pkg::OTR_ASLEEP: begin
				if (src_off || i_wake_req || wake_pin_s) begin
					state_d = otr_pkg::OTR_WAKING;
				end
			end
			otr_pkg::OTR_WAKING: begin
				// One cycle to let the fast RC restart
				state_d = otr_pkg::OTR_AWAKE;
			end
			default: begin
				state_d = otr_pkg::OTR_AWAKE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= otr_pkg::OTR_AWAKE;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================
	// Sticky refusal flag
	// A new refusal beats a clear in the same cycle
	always_comb begin
		refused_d = refused_q;
		if (we_status && i_wdata[otr_pkg::ST_REFUSED_POS]) begin
			refused_d = 1'b0;
		end
		if (refuse_evt) begin
			refused_d = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			refused_q <= 1'b0;
		end else begin
			refused_q <= refused_d;
		end
	end

	// ==========================================
	// Oscillator run levels
	// Codes 2 and 3 are folded so the analog side sees one
	// codes 2 and 3 equal
	assign range_raw = 2'(fld(fast_rc_q, otr_pkg::FRC_RANGE_LSB, 16'h0003));
	assign range_eff = range_raw[1] ? 2'h2 : range_raw;

	always_comb begin
		slow_rc_on_d = ~src_off;
		fast_rc_on_d = ~frc_off & (state_d != otr_pkg::OTR_ASLEEP);
	end

	// Registered so analog enables never glitch
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			slow_rc_on_q <= 1'b1;
			fast_rc_on_q <= 1'b1;
			range_q <= 2'h0;
			refuse_pulse_q <= 1'b0;
		end else begin
			slow_rc_on_q <= slow_rc_on_d;
			fast_rc_on_q <= fast_rc_on_d;
			range_q <= range_eff;
			refuse_pulse_q <= refuse_evt;
		end
	end

	// ==========================================
	// Read path
	// Status word shows live sequencer state
	always_comb begin
		status_word = 16'h0000;
		status_word[otr_pkg::ST_SLEEP_POS] = (state_q == otr_pkg::OTR_ASLEEP);
		status_word[otr_pkg::ST_FRC_POS] = fast_rc_on_q;
		status_word[otr_pkg::ST_REFUSED_POS] = refused_q;
	end

	always_comb begin
		rdata_d = 16'h0000;
		if (i_rd) begin
			if (hit(i_addr, otr_pkg::OFS_SLOW_RC)) begin
				rdata_d = slow_rc_q;
			end else if (hit(i_addr, otr_pkg::OFS_SLOW_XTAL)) begin
				rdata_d = slow_xtal_q;
			end else if (hit(i_addr, otr_pkg::OFS_FAST_RC)) begin
				rdata_d = fast_rc_q;
			end else if (hit(i_addr, otr_pkg::OFS_LP_RC)) begin
				rdata_d = lp_rc_q;
			end else if (hit(i_addr, otr_pkg::OFS_REF_TRIM)) begin
				rdata_d = ref_q;
			end else if (hit(i_addr, otr_pkg::OFS_OSC_STATUS)) begin
				rdata_d = status_word;
			end
		end
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// ==========================================
	// Analog field outputs
	// slow RC trim out
	assign o_slow_rc_trim = 4'(fld(slow_rc_q, otr_pkg::SRC_TRIM_LSB, 16'h000F));
	assign o_slow_rc_on = slow_rc_on_q;

	assign o_slow_xtal_amp_reg_off = slow_xtal_q[otr_pkg::SX_AMPOFF_POS];
	assign o_slow_xtal_bias_current =
		4'(fld(slow_xtal_q, otr_pkg::SX_CUR_LSB, 16'h000F));
	assign o_slow_xtal_bias_resistor =
		2'(fld(slow_xtal_q, otr_pkg::SX_RBIAS_LSB, 16'h0003));
	assign o_slow_xtal_on = slow_xtal_q[otr_pkg::SX_ON_POS];

	assign o_fast_rc_cap_adjust = 4'(fld(fast_rc_q, otr_pkg::FRC_CAP_LSB, 16'h000F));
	assign o_fast_rc_coarse_range = range_q;
	assign o_fast_rc_bias = 4'(fld(fast_rc_q, otr_pkg::FRC_BIAS_LSB, 16'h000F));
	assign o_fast_rc_on = fast_rc_on_q;

	assign o_lp_rc_ldo_bias = 4'(fld(lp_rc_q, otr_pkg::LRC_BIAS_LSB, 16'h000F));
	assign o_lp_rc_on = lp_rc_q[otr_pkg::LRC_ON_POS];
	assign o_lp_rc_unit_cap = lp_rc_q[otr_pkg::LRC_UNIT_POS];
	assign o_lp_rc_cap_adjust = 5'(fld(lp_rc_q, otr_pkg::LRC_CAP_LSB, 16'h001F));
	assign o_lp_rc_res_adjust = lp_rc_q[otr_pkg::LRC_RES_POS];

	// Signed two's complement codes, zero is nominal
	// current trim out
	assign o_ref_current_trim = 5'(fld(ref_q, otr_pkg::REF_I_LSB, 16'h001F));
	assign o_ref_voltage_trim = 5'(fld(ref_q, otr_pkg::REF_V_LSB, 16'h001F));

	// ==========================================
	// Sleep status outputs
	assign o_sleep_active = status_word[otr_pkg::ST_SLEEP_POS];
	assign o_sleep_refused = refuse_pulse_q;

endmodule : oscillator_trim_regs

// *** bench/otr_monitor.sv ***
// Concurrent checks on the oscillator trim register ports
module otr_monitor (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [31:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic [3:0] o_slow_rc_trim,
	input wire logic o_slow_rc_on,
	input wire logic o_slow_xtal_amp_reg_off,
	input wire logic [3:0] o_slow_xtal_bias_current,
	input wire logic [1:0] o_slow_xtal_bias_resistor,
	input wire logic o_slow_xtal_on,
	input wire logic [3:0] o_fast_rc_cap_adjust,
	input wire logic [1:0] o_fast_rc_coarse_range,
	input wire logic o_fast_rc_on,
	input wire logic [4:0] o_ref_current_trim,
	input wire logic [4:0] o_ref_voltage_trim,
	input wire logic o_sleep_active,
	input wire logic o_sleep_refused
);
	// ==========================================
	// Write decodes
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	logic wr_src;
	logic wr_frc;
	logic wr_ref;
	// Exact address match only, as the bus decoder does
	assign wr_src = i_wr && (i_addr == otr_pkg::OFS_SLOW_RC);
	assign wr_frc = i_wr && (i_addr == otr_pkg::OFS_FAST_RC);
	assign wr_ref = i_wr && (i_addr == otr_pkg::OFS_REF_TRIM);

	// ==========================================
	// Assertions
	AST_SRC_TRIM: assert property (wr_src |=> o_slow_rc_trim == $past(i_wdata[4:1]))
		else $error("slow rc trim not loaded");
	// Run enables follow the off bit at the write edge itself
	AST_SRC_OFF: assert property (wr_src |=> o_slow_rc_on == !$past(i_wdata[0]))
		else $error("slow rc enable wrong");
	AST_NO_SLEEP: assert property (!o_slow_rc_on |-> !o_sleep_active)
		else $error("asleep with slow rc stopped");
	AST_FRC_SLEEP: assert property (o_sleep_active |-> !o_fast_rc_on)
		else $error("fast rc running in sleep");
	AST_FRC_OFF: assert property (wr_frc && i_wdata[0] |=> !o_fast_rc_on)
		else $error("fast rc not stopped");
	AST_FRC_RANGE: assert property (wr_frc |-> ##2 o_fast_rc_coarse_range ==
		($past(i_wdata[6], 2) ? 2'h2 : $past(i_wdata[6:5], 2)))
		else $error("coarse range not folded");
	AST_FRC_CAP: assert property (wr_frc |=> o_fast_rc_cap_adjust == $past(i_wdata[10:7]))
		else $error("fast rc cap not loaded");
	AST_SX_READ: assert property (i_rd && i_addr == otr_pkg::OFS_SLOW_XTAL |=>
		o_rdata == {8'h00, o_slow_xtal_amp_reg_off, o_slow_xtal_bias_current,
		o_slow_xtal_bias_resistor, o_slow_xtal_on})
		else $error("crystal readback mismatch");
	AST_REF_LOAD: assert property (wr_ref |=>
		{o_ref_current_trim, o_ref_voltage_trim} == $past(i_wdata[9:0]))
		else $error("reference trim not loaded");
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside read cycle");

	// ==========================================
	// Coverage of main scenarios
	COV_WR_SRC: cover property (wr_src);
	COV_SLEEP: cover property ($rose(o_sleep_active));
	COV_REFUSE: cover property (o_sleep_refused);
endmodule : otr_monitor

bind oscillator_trim_regs otr_monitor u_mon (.*);

// *** bench/oscillator_trim_regs_bench.sv ***
// Directed bench for the oscillator trim registers
module oscillator_trim_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk, i_rst_b, i_wr, i_rd, i_sleep_req, i_wake_req, i_wakeup_pin;
	logic [31:0] i_addr;
	logic [15:0] i_wdata, o_rdata;
	logic [3:0] o_slow_rc_trim, o_slow_xtal_bias_current, o_fast_rc_cap_adjust;
	logic [3:0] o_fast_rc_bias, o_lp_rc_ldo_bias;
	logic [1:0] o_slow_xtal_bias_resistor, o_fast_rc_coarse_range;
	logic [4:0] o_lp_rc_cap_adjust, o_ref_current_trim, o_ref_voltage_trim;
	logic o_slow_rc_on, o_slow_xtal_amp_reg_off, o_slow_xtal_on, o_fast_rc_on;
	logic o_lp_rc_unit_cap, o_lp_rc_res_adjust, o_lp_rc_on, o_sleep_active, o_sleep_refused;
	int n_fail = 0;
	int n_tests = 0;
	// Register map, reset values and implemented bits, in one order
	logic [31:0] ofs [5] = '{otr_pkg::OFS_SLOW_RC, otr_pkg::OFS_SLOW_XTAL,
		otr_pkg::OFS_FAST_RC, otr_pkg::OFS_LP_RC, otr_pkg::OFS_REF_TRIM};
	logic [15:0] rstv [5] = '{16'h000E, 16'h002E, 16'h078E, 16'h0AFC, 16'h0000};
	logic [15:0] msk [5] = '{16'h001F, 16'h00FF, 16'h07FF, 16'h0FFF, 16'h03FF};

	oscillator_trim_regs uut (.*);

	// ==========================================
	// Clock and watchdog
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#20000;
		n_fail++;
		close_out();
	end

	// ==========================================
	// Bus and check tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, input logic [15:0] exp);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : cyc
	task automatic slp();
		@(posedge i_mclk);
		i_sleep_req <= 1'b1;
		@(posedge i_mclk);
		i_sleep_req <= 1'b0;
		#1;
	endtask : slp
	task automatic close_out();
		$display("TB: tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	// ==========================================
	// Main sequence
	initial begin
		i_rst_b = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		{i_wr, i_rd, i_sleep_req, i_wake_req, i_wakeup_pin} = 5'h00;
		repeat (5) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		#1;
		chk(16'(o_slow_rc_on), 16'h0001);
		chk(16'(o_fast_rc_on), 16'h0001);
		for (int i = 0; i < 5; i++) rd(ofs[i], rstv[i]);
		for (int i = 0; i < 5; i++) begin
			wr(ofs[i], 16'hFFFF);
			rd(ofs[i], msk[i]);
		end
		wr(otr_pkg::OFS_SLOW_RC, 16'h001E);
		chk(16'(o_slow_rc_trim), 16'h000F);
		cyc(1);
		chk(16'(o_slow_rc_on), 16'h0001);
		wr(otr_pkg::OFS_SLOW_XTAL, 16'h00AB);
		chk(16'({o_slow_xtal_amp_reg_off, o_slow_xtal_bias_current,
			o_slow_xtal_bias_resistor, o_slow_xtal_on}), 16'h00AB);
		// Every coarse range code, with 3 acting as 2
		for (int c = 0; c < 4; c++) begin
			wr(otr_pkg::OFS_FAST_RC, 16'((3 << 7) | (c << 5) | (9 << 1)));
			cyc(1);
			chk(16'(o_fast_rc_coarse_range), 16'((c == 3) ? 2 : c));
			chk(16'(o_fast_rc_cap_adjust), 16'h0003);
			chk(16'(o_fast_rc_bias), 16'h0009);
		end
		wr(otr_pkg::OFS_FAST_RC, 16'h0001);
		cyc(1);
		chk(16'(o_fast_rc_on), 16'h0000);
		wr(otr_pkg::OFS_FAST_RC, 16'h0000);
		wr(otr_pkg::OFS_LP_RC, 16'h0A5B);
		chk(16'({o_lp_rc_ldo_bias, o_lp_rc_unit_cap, o_lp_rc_cap_adjust,
			o_lp_rc_res_adjust, o_lp_rc_on}), 16'h0A5B);
		wr(otr_pkg::OFS_REF_TRIM, 16'hFE11);
		chk(16'({o_ref_current_trim, o_ref_voltage_trim}), 16'h0211);
		// Near-miss addresses must not alias a register
		wr(32'h5000_0021, 16'hFFFF);
		wr(32'h5000_0028, 16'hFFFF);
		rd(32'h5000_0021, 16'h0000);
		rd(otr_pkg::OFS_SLOW_RC, 16'h001E);
		rd(otr_pkg::OFS_REF_TRIM, 16'h0211);
		slp();
		chk(16'(o_sleep_active), 16'h0001);
		chk(16'(o_fast_rc_on), 16'h0000);
		@(posedge i_mclk);
		i_wake_req <= 1'b1;
		@(posedge i_mclk);
		i_wake_req <= 1'b0;
		#1;
		chk(16'(o_sleep_active), 16'h0000);
		cyc(1);
		chk(16'(o_fast_rc_on), 16'h0001);
		wr(otr_pkg::OFS_SLOW_RC, 16'h0001);
		cyc(1);
		chk(16'(o_slow_rc_on), 16'h0000);
		slp();
		chk(16'(o_sleep_active), 16'h0000);
		chk(16'(o_sleep_refused), 16'h0001);
		// Sticky refusal reads back, then clears on a one written
		rd(otr_pkg::OFS_OSC_STATUS, 16'h0006);
		wr(otr_pkg::OFS_OSC_STATUS, 16'h0004);
		rd(otr_pkg::OFS_OSC_STATUS, 16'h0002);
		wr(otr_pkg::OFS_SLOW_RC, 16'h0000);
		cyc(1);
		slp();
		chk(16'(o_sleep_active), 16'h0001);
		// Pin wake goes through a synchroniser, so allow a few cycles
		@(posedge i_mclk);
		i_wakeup_pin <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			cyc(1);
			if (!o_sleep_active) break;
		end
		chk(16'(o_sleep_active), 16'h0000);
		@(posedge i_mclk);
		i_wakeup_pin <= 1'b0;
		cyc(4);
		slp();
		chk(16'(o_sleep_active), 16'h0001);
		// Stopping the slow RC ends sleep at the same edge
		wr(otr_pkg::OFS_SLOW_RC, 16'h0001);
		chk(16'(o_slow_rc_on), 16'h0000);
		chk(16'(o_sleep_active), 16'h0000);
		cyc(1);
		chk(16'(o_sleep_active), 16'h0000);
		cyc(2);
		close_out();
	end
endmodule : oscillator_trim_regs_bench
